// *** rtl/pief_pkg.sv ***
// Package for the peripheral interrupt enable and request flag block.
// Assumes a single 10 MHz clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package pief_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// Byte addresses of the word registers
	localparam logic [ADDR_W-1:0] OFF_ENABLE_TWO  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_REQUEST_ONE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_ENABLE_ONE  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CONTROL = 8'h0C;

	// Request register bit positions
	localparam int REQ_CONV    = 6;
	localparam int REQ_RX      = 5;
	localparam int REQ_TX      = 4;
	localparam int REQ_SYNC    = 3;
	localparam int REQ_CAPCOMP = 2;
	localparam int REQ_T2      = 1;
	localparam int REQ_T1      = 0;
	localparam int REQ_FLAGS   = 7;

	// Control register bit positions
	localparam int CTL_GIE = 7;
	localparam int CTL_PME = 6;

	// Implemented and software-writable masks
	localparam logic [REG_W-1:0] EN2_MASK    = 8'hF0;
	localparam logic [REG_W-1:0] EN1_MASK    = 8'h7F;
	localparam logic [REG_W-1:0] REQ_SW_MASK = 8'h4F;
	localparam logic [REG_W-1:0] CTL_MASK    = 8'hC0;
	localparam logic [REG_W-1:0] RST_VALUE   = 8'h00;
	localparam int EN2_LSB = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CC_CAPTURE = 3'h1,
		CC_COMPARE = 3'h2,
		CC_PWM     = 3'h4
	} pief_ccmode_t;

	typedef enum logic [1:0] {
		BS_IDLE = 2'h1,
		BS_RESP = 2'h2
	} pief_bus_state_t;
endpackage
`default_nettype wire

// *** rtl/pief_flag_bank.sv ***
// Sticky flag bank: hardware set, per-bit clear pulse, software write.
// Assumes all inputs come from logic on the same clock.
`default_nettype none
module pief_flag_bank #(
	parameter int W = 7
) (
	// Clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	// Flag control
	input  wire logic [W-1:0] i_set,
	input  wire logic [W-1:0] i_clr,
	input  wire logic [W-1:0] i_wr_en,
	input  wire logic [W-1:0] i_wdata,
	// Flag state
	output logic      [W-1:0] o_flags
);
	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// Set wins so an event in the clearing cycle is kept
	assign flags_next = i_set | (~i_clr & ((i_wr_en & i_wdata) | (~i_wr_en & flags_reg)));
	assign o_flags    = flags_reg;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end
endmodule
`default_nettype wire

// *** rtl/pief_axil_slave.sv ***
// AXI4-Lite slave front end: collects a write, gives one write pulse,
// and registers read data. Decoding is left to the parent.
`default_nettype none
module pief_axil_slave (
	// Clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	// Write address and data
	input  wire logic [pief_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                       i_awvalid,
	output logic                            o_awready,
	input  wire logic [pief_pkg::DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                 i_wstrb,
	input  wire logic                       i_wvalid,
	output logic                            o_wready,
	// Write response
	output logic [1:0]                      o_bresp,
	output logic                            o_bvalid,
	input  wire logic                       i_bready,
	// Read
	input  wire logic                       i_arvalid,
	output logic                            o_arready,
	output logic [pief_pkg::DATA_W-1:0]     o_rdata,
	output logic [1:0]                      o_rresp,
	output logic                            o_rvalid,
	input  wire logic                       i_rready,
	// Parent side
	output logic [pief_pkg::ADDR_W-1:0]     o_wr_addr_now,
	input  wire logic                       i_wr_ok,
	input  wire logic [pief_pkg::DATA_W-1:0] i_rd_data,
	input  wire logic                       i_rd_ok,
	output logic                            o_wr_pulse,
	output logic [pief_pkg::ADDR_W-1:0]     o_wr_addr,
	output logic [pief_pkg::REG_W-1:0]      o_wr_byte,
	output logic                            o_wr_lane0
);
	pief_pkg::pief_bus_state_t ws_reg, ws_next, rs_reg, rs_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic awready_reg, wready_reg, arready_reg, bvalid_reg, rvalid_reg;
	logic [pief_pkg::ADDR_W-1:0] awaddr_reg;
	logic [pief_pkg::DATA_W-1:0] wdata_reg, rdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic wr_pulse_reg;
	logic [pief_pkg::ADDR_W-1:0] wr_addr_reg;
	logic [pief_pkg::REG_W-1:0] wr_byte_reg;
	logic wr_lane0_reg;

	wire aw_hs  = i_awvalid & awready_reg;
	wire w_hs   = i_wvalid & wready_reg;
	wire ar_hs  = i_arvalid & arready_reg;
	wire aw_any = aw_held_reg | aw_hs;
	wire w_any  = w_held_reg | w_hs;
	wire do_wr  = aw_any & w_any & (ws_reg == pief_pkg::BS_IDLE);
	wire b_done = bvalid_reg & i_bready;
	wire r_done = rvalid_reg & i_rready;
	wire [pief_pkg::DATA_W-1:0] wdata_now = w_hs ? i_wdata : wdata_reg;
	wire [3:0] wstrb_now = w_hs ? i_wstrb : wstrb_reg;

	assign o_wr_addr_now = aw_hs ? i_awaddr : awaddr_reg;
	assign aw_held_next  = aw_any & ~do_wr;
	assign w_held_next   = w_any & ~do_wr;

	always_comb begin
		ws_next = ws_reg;
		case (ws_reg)
			pief_pkg::BS_IDLE: if (do_wr) ws_next = pief_pkg::BS_RESP;
			pief_pkg::BS_RESP: if (b_done) ws_next = pief_pkg::BS_IDLE;
			default: ws_next = pief_pkg::BS_IDLE;
		endcase
		rs_next = rs_reg;
		case (rs_reg)
			pief_pkg::BS_IDLE: if (ar_hs) rs_next = pief_pkg::BS_RESP;
			pief_pkg::BS_RESP: if (r_done) rs_next = pief_pkg::BS_IDLE;
			default: rs_next = pief_pkg::BS_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ws_reg       <= pief_pkg::BS_IDLE;
			rs_reg       <= pief_pkg::BS_IDLE;
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awready_reg  <= 1'b0;
			wready_reg   <= 1'b0;
			arready_reg  <= 1'b0;
			bvalid_reg   <= 1'b0;
			rvalid_reg   <= 1'b0;
			bresp_reg    <= pief_pkg::RESP_OKAY;
			rresp_reg    <= pief_pkg::RESP_OKAY;
			awaddr_reg   <= '0;
			wdata_reg    <= '0;
			wstrb_reg    <= '0;
			rdata_reg    <= '0;
			wr_pulse_reg <= 1'b0;
			wr_addr_reg  <= '0;
			wr_byte_reg  <= '0;
			wr_lane0_reg <= 1'b0;
		end else begin
			ws_reg       <= ws_next;
			rs_reg       <= rs_next;
			aw_held_reg  <= aw_held_next;
			w_held_reg   <= w_held_next;
			awready_reg  <= (ws_next == pief_pkg::BS_IDLE) & ~aw_held_next;
			wready_reg   <= (ws_next == pief_pkg::BS_IDLE) & ~w_held_next;
			arready_reg  <= (rs_next == pief_pkg::BS_IDLE);
			bvalid_reg   <= (ws_next == pief_pkg::BS_RESP);
			rvalid_reg   <= (rs_next == pief_pkg::BS_RESP);
			wr_pulse_reg <= do_wr;
			if (aw_hs) awaddr_reg <= i_awaddr;
			if (w_hs) begin
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (do_wr) begin
				bresp_reg    <= i_wr_ok ? pief_pkg::RESP_OKAY : pief_pkg::RESP_SLVERR;
				wr_addr_reg  <= o_wr_addr_now;
				wr_byte_reg  <= wdata_now[pief_pkg::REG_W-1:0];
				wr_lane0_reg <= wstrb_now[0];
			end
			if (ar_hs) begin
				rdata_reg <= i_rd_data;
				rresp_reg <= i_rd_ok ? pief_pkg::RESP_OKAY : pief_pkg::RESP_SLVERR;
			end
		end
	end

	assign o_awready  = awready_reg;
	assign o_wready   = wready_reg;
	assign o_arready  = arready_reg;
	assign o_bvalid   = bvalid_reg;
	assign o_bresp    = bresp_reg;
	assign o_rvalid   = rvalid_reg;
	assign o_rresp    = rresp_reg;
	assign o_rdata    = rdata_reg;
	assign o_wr_pulse = wr_pulse_reg;
	assign o_wr_addr  = wr_addr_reg;
	assign o_wr_byte  = wr_byte_reg;
	assign o_wr_lane0 = wr_lane0_reg;
endmodule
`default_nettype wire

// *** rtl/pief_top.sv ***
// Peripheral interrupt enables, request flags and request combining.
// Assumes event inputs are one-cycle pulses from logic on i_ref_clk.
//
// Notes on behaviour
// - No peripheral request leaves the block unless the peripheral master enable is set.
// - Every flag sets on its event regardless of its own enable or the global enable.
// - Enable register two holds oscillator fail, two comparators and write-done in bits 7..4; bits 3..0 read zero.
// - Bit 7 of request register one always reads zero.
// - The conversion flag sets on conversion done and holds until software clears it.
// - The receive flag is read-only, sets on received data and clears on a receive data read.
// - The transmit flag is read-only, sets on buffer empty and clears on a transmit data write.
// - The synchronous serial flag sets on transfer done and holds until software clears it.
// - The capture/compare flag sets on capture or compare match per mode, never in pulse-width mode.
// - The timer two flag sets on a period match and holds until cleared.
// - The timer one flag sets on counter overflow and holds until cleared.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`default_nettype none
module pief_top (
	// Clock and reset
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst,
	// AXI4-Lite write
	input  wire logic [pief_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [pief_pkg::DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	output logic [1:0]                       o_bresp,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	// AXI4-Lite read
	input  wire logic [pief_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	output logic [pief_pkg::DATA_W-1:0]      o_rdata,
	output logic [1:0]                       o_rresp,
	output logic                             o_rvalid,
	input  wire logic                        i_rready,
	// Peripheral events
	input  wire logic                        i_conversion_done,
	input  wire logic                        i_serial_rx_arrived,
	input  wire logic                        i_serial_rx_data_read,
	input  wire logic                        i_serial_tx_emptied,
	input  wire logic                        i_serial_tx_data_write,
	input  wire logic                        i_sync_serial_done,
	input  wire pief_pkg::pief_ccmode_t      i_capcomp_mode,
	input  wire logic                        i_capture_event,
	input  wire logic                        i_compare_match,
	input  wire logic                        i_timer_two_match,
	input  wire logic                        i_timer_one_overflow,
	input  wire logic [3:0]                  i_request_two_flags,
	// Core side
	output logic                             o_periph_irq,
	output logic                             o_global_irq_enable,
	output logic [pief_pkg::REG_W-1:0]       o_request_one
);
	logic [pief_pkg::REG_W-1:0] en_two_reg, en_one_reg, ctl_reg;
	logic [pief_pkg::REG_W-1:0] en_two_next, en_one_next, ctl_next;
	logic irq_reg, irq_next;
	logic [pief_pkg::REG_W-1:0] req_out_reg;
	logic [pief_pkg::REQ_FLAGS-1:0] flags, flag_set, flag_clr, flag_wr_en;
	logic [pief_pkg::ADDR_W-1:0] wr_addr_now, wr_addr;
	logic [pief_pkg::REG_W-1:0] wr_byte;
	logic wr_pulse, wr_lane0;

	function automatic logic is_mapped(input logic [pief_pkg::ADDR_W-1:0] a);
		is_mapped = (a == pief_pkg::OFF_ENABLE_TWO) || (a == pief_pkg::OFF_REQUEST_ONE) ||
			(a == pief_pkg::OFF_ENABLE_ONE) || (a == pief_pkg::OFF_IRQ_CONTROL);
	endfunction

	function automatic logic wr_hits(input logic [pief_pkg::ADDR_W-1:0] a, input logic [pief_pkg::ADDR_W-1:0] off,
		input logic pulse, input logic lane0);
		wr_hits = pulse && lane0 && (a == off);
	endfunction

	// Register file read view
	wire [pief_pkg::REG_W-1:0] req_view = {1'b0, flags};
	wire [pief_pkg::REG_W-1:0] rd_byte =
		(i_araddr == pief_pkg::OFF_ENABLE_TWO)  ? (en_two_reg & pief_pkg::EN2_MASK) :
		(i_araddr == pief_pkg::OFF_REQUEST_ONE) ? req_view :
		(i_araddr == pief_pkg::OFF_ENABLE_ONE)  ? en_one_reg :
		(i_araddr == pief_pkg::OFF_IRQ_CONTROL) ? ctl_reg : pief_pkg::RST_VALUE;
	wire [pief_pkg::DATA_W-1:0] rd_word = {{(pief_pkg::DATA_W-pief_pkg::REG_W){1'b0}}, rd_byte};

	pief_axil_slave u_bus (
		.i_ref_clk     (i_ref_clk),
		.i_rst         (i_rst),
		.i_awaddr      (i_awaddr),
		.i_awvalid     (i_awvalid),
		.o_awready     (o_awready),
		.i_wdata       (i_wdata),
		.i_wstrb       (i_wstrb),
		.i_wvalid      (i_wvalid),
		.o_wready      (o_wready),
		.o_bresp       (o_bresp),
		.o_bvalid      (o_bvalid),
		.i_bready      (i_bready),
		.i_arvalid     (i_arvalid),
		.o_arready     (o_arready),
		.o_rdata       (o_rdata),
		.o_rresp       (o_rresp),
		.o_rvalid      (o_rvalid),
		.i_rready      (i_rready),
		.o_wr_addr_now (wr_addr_now),
		.i_wr_ok       (is_mapped(wr_addr_now)),
		.i_rd_data     (rd_word),
		.i_rd_ok       (is_mapped(i_araddr)),
		.o_wr_pulse    (wr_pulse),
		.o_wr_addr     (wr_addr),
		.o_wr_byte     (wr_byte),
		.o_wr_lane0    (wr_lane0)
	);

	// Write decode
	wire wr_en_two = wr_hits(wr_addr, pief_pkg::OFF_ENABLE_TWO, wr_pulse, wr_lane0);
	wire wr_req    = wr_hits(wr_addr, pief_pkg::OFF_REQUEST_ONE, wr_pulse, wr_lane0);
	wire wr_en_one = wr_hits(wr_addr, pief_pkg::OFF_ENABLE_ONE, wr_pulse, wr_lane0);
	wire wr_ctl    = wr_hits(wr_addr, pief_pkg::OFF_IRQ_CONTROL, wr_pulse, wr_lane0);

	assign en_two_next = wr_en_two ? (wr_byte & pief_pkg::EN2_MASK) : en_two_reg;
	assign en_one_next = wr_en_one ? (wr_byte & pief_pkg::EN1_MASK) : en_one_reg;
	assign ctl_next    = wr_ctl ? (wr_byte & pief_pkg::CTL_MASK) : ctl_reg;

	// Flag sources; pulse-width mode raises nothing on the capture/compare flag
	wire capcomp_hit = ((i_capcomp_mode == pief_pkg::CC_CAPTURE) & i_capture_event) |
		((i_capcomp_mode == pief_pkg::CC_COMPARE) & i_compare_match);
	always_comb begin
		flag_set = '0;
		flag_set[pief_pkg::REQ_CONV]    = i_conversion_done;
		flag_set[pief_pkg::REQ_RX]      = i_serial_rx_arrived;
		flag_set[pief_pkg::REQ_TX]      = i_serial_tx_emptied;
		flag_set[pief_pkg::REQ_SYNC]    = i_sync_serial_done;
		flag_set[pief_pkg::REQ_CAPCOMP] = capcomp_hit;
		flag_set[pief_pkg::REQ_T2]      = i_timer_two_match;
		flag_set[pief_pkg::REQ_T1]      = i_timer_one_overflow;
		flag_clr = '0;
		flag_clr[pief_pkg::REQ_RX] = i_serial_rx_data_read;
		flag_clr[pief_pkg::REQ_TX] = i_serial_tx_data_write;
	end
	// Receive and transmit bits are outside the writable mask
	assign flag_wr_en = {pief_pkg::REQ_FLAGS{wr_req}} & pief_pkg::REQ_SW_MASK[pief_pkg::REQ_FLAGS-1:0];

	pief_flag_bank #(
		.W (pief_pkg::REQ_FLAGS)
	) u_flags (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_set     (flag_set),
		.i_clr     (flag_clr),
		.i_wr_en   (flag_wr_en),
		.i_wdata   (wr_byte[pief_pkg::REQ_FLAGS-1:0]),
		.o_flags   (flags)
	);

	// Request combining; the global enable is left to the core
	wire any_one = |(flags & en_one_reg[pief_pkg::REQ_FLAGS-1:0]);
	wire any_two = |(i_request_two_flags & en_two_reg[pief_pkg::REG_W-1:pief_pkg::EN2_LSB]);
	assign irq_next = ctl_reg[pief_pkg::CTL_PME] & (any_one | any_two);

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			en_two_reg  <= pief_pkg::RST_VALUE;
			en_one_reg  <= pief_pkg::RST_VALUE;
			ctl_reg     <= pief_pkg::RST_VALUE;
			irq_reg     <= 1'b0;
			req_out_reg <= pief_pkg::RST_VALUE;
		end else begin
			en_two_reg  <= en_two_next;
			en_one_reg  <= en_one_next;
			ctl_reg     <= ctl_next;
			irq_reg     <= irq_next;
			req_out_reg <= req_view;
		end
	end

	assign o_periph_irq        = irq_reg;
	assign o_global_irq_enable = ctl_reg[pief_pkg::CTL_GIE];
	assign o_request_one       = req_out_reg;

	wire arready_sample = i_arvalid && o_arready && (i_araddr == pief_pkg::OFF_ENABLE_TWO);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	irq_gated_a: assert property (!ctl_reg[pief_pkg::CTL_PME] |=> !o_periph_irq)
		else $error("Request raised with master enable clear");
	flag_set_a: assert property (i_conversion_done && !ctl_reg[pief_pkg::CTL_GIE] |=> flags[pief_pkg::REQ_CONV])
		else $error("Conversion flag missed while disabled");
	en_two_read_a: assert property (arready_sample |=> o_rdata[3:0] == 4'h0 && o_rdata[31:8] == 24'h00_0000)
		else $error("Enable two reserved bits not zero");
	req_bit7_a: assert property (##1 !o_request_one[7])
		else $error("Request bit 7 read as one");
	conv_hold_a: assert property (flags[pief_pkg::REQ_CONV] && !wr_req |=> flags[pief_pkg::REQ_CONV])
		else $error("Conversion flag dropped without a clear");
	rx_clear_a: assert property (i_serial_rx_data_read && !i_serial_rx_arrived |=> !flags[pief_pkg::REQ_RX])
		else $error("Receive flag not cleared by a data read");
	rx_readonly_a: assert property (flags[pief_pkg::REQ_RX] && !i_serial_rx_data_read |=> flags[pief_pkg::REQ_RX])
		else $error("Receive flag lost without a data read");
	tx_clear_a: assert property (i_serial_tx_data_write && !i_serial_tx_emptied |=> !flags[pief_pkg::REQ_TX])
		else $error("Transmit flag not cleared by a data write");
	sync_set_a: assert property (i_sync_serial_done |=> flags[pief_pkg::REQ_SYNC][*2] or
		(flags[pief_pkg::REQ_SYNC] ##1 $past(wr_req)))
		else $error("Synchronous serial flag not held");
	pwm_quiet_a: assert property (i_capcomp_mode == pief_pkg::CC_PWM && !wr_req &&
		!flags[pief_pkg::REQ_CAPCOMP] |=> !flags[pief_pkg::REQ_CAPCOMP])
		else $error("Capture/compare flag set in pulse-width mode");
	timer_two_a: assert property (i_timer_two_match |=> flags[pief_pkg::REQ_T2])
		else $error("Timer two flag missed");
	timer_one_a: assert property ($rose(i_timer_one_overflow) |=> flags[pief_pkg::REQ_T1])
		else $error("Timer one flag missed");
	irq_raise_a: assert property (ctl_reg[pief_pkg::CTL_PME] && (|(flags & en_one_reg[6:0]))
		|=> o_periph_irq)
		else $error("Enabled flag raised no request");

	irq_seen_c: cover property (ctl_reg[pief_pkg::CTL_PME] ##1 o_periph_irq);
	write_done_c: cover property (o_bvalid && i_bready && o_bresp == pief_pkg::RESP_OKAY);
	bad_addr_c: cover property (o_rvalid && o_rresp == pief_pkg::RESP_SLVERR);
	set_clear_c: cover property (wr_req && flag_set[pief_pkg::REQ_CONV]);
endmodule
`default_nettype wire

// *** verif/pief_event_src.sv ***
// Peripheral event source model: one-cycle event pulse per bench command.
// Assumes commands from the bench on i_ref_clk; index 15 fires nothing.
`default_nettype none
module pief_event_src (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	// Command
	input  wire logic       i_go,
	input  wire logic [3:0] i_pick,
	// Event pulses
	output logic      [9:0] o_ev
);
	timeunit 1ns;
	timeprecision 1ns;
	// One cycle only: the block counts every high cycle as a fresh event
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			o_ev <= 10'h000;
		else if (i_go)
			o_ev <= 10'h001 << i_pick;
		else
			o_ev <= 10'h000;
	end
endmodule
`default_nettype wire

// *** verif/test_peripheral_irq_enable_flags.sv ***
// Testbench for the peripheral interrupt flag block: AXI4-Lite register
// access, event pulses from the source model, request gating, resets.
// Assumes the byte map and latencies given in the designer's hand-over.
`default_nettype none
module test_peripheral_irq_enable_flags;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0]            ev1;
		pief_pkg::pief_ccmode_t mode;
		logic [7:0]            exp1;
		logic [3:0]            ev2;
		logic [7:0]            exp2;
	} pief_row_t;
	logic                   i_ref_clk = 1'h0;
	logic                   i_rst = 1'h1;
	logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
	logic [31:0]            wdata = 32'h0000_0000, rdat;
	logic                   awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic                   awready, wready, bvalid, arready, rvalid, irq, global_irq_enable, go = 1'h0;
	logic [1:0]             bresp, rresp, resp;
	logic [31:0]            rdata;
	logic [7:0]             req1;
	logic [3:0]             pick = 4'hF, req2 = 4'h0, strb = 4'hF;
	logic [9:0]             ev;
	pief_pkg::pief_ccmode_t mode = pief_pkg::CC_CAPTURE;
	int                     error_cnt = 0, total_checks = 0;
	localparam logic [7:0]  RQ = pief_pkg::OFF_REQUEST_ONE;
	pief_row_t rows [11] = '{
		'{4'h0, pief_pkg::CC_CAPTURE, 8'h40, 4'hF, 8'h00},
		'{4'h1, pief_pkg::CC_CAPTURE, 8'h20, 4'h2, 8'h00},
		'{4'h3, pief_pkg::CC_CAPTURE, 8'h10, 4'h4, 8'h00},
		'{4'h5, pief_pkg::CC_CAPTURE, 8'h08, 4'hF, 8'h00},
		'{4'h6, pief_pkg::CC_CAPTURE, 8'h04, 4'hF, 8'h00},
		'{4'h7, pief_pkg::CC_COMPARE, 8'h04, 4'hF, 8'h00},
		'{4'h6, pief_pkg::CC_COMPARE, 8'h00, 4'hF, 8'h00},
		'{4'h6, pief_pkg::CC_PWM,     8'h00, 4'hF, 8'h00},
		'{4'h7, pief_pkg::CC_PWM,     8'h00, 4'hF, 8'h00},
		'{4'h8, pief_pkg::CC_CAPTURE, 8'h02, 4'hF, 8'h00},
		'{4'h9, pief_pkg::CC_CAPTURE, 8'h01, 4'hF, 8'h00}};

	pief_event_src i_pief_event_src (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_go(go), .i_pick(pick), .o_ev(ev));

	pief_top i_pief_top (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(strb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready),
		.i_conversion_done(ev[0]), .i_serial_rx_arrived(ev[1]), .i_serial_rx_data_read(ev[2]),
		.i_serial_tx_emptied(ev[3]), .i_serial_tx_data_write(ev[4]), .i_sync_serial_done(ev[5]),
		.i_capcomp_mode(mode), .i_capture_event(ev[6]), .i_compare_match(ev[7]),
		.i_timer_two_match(ev[8]), .i_timer_one_overflow(ev[9]), .i_request_two_flags(req2),
		.o_periph_irq(irq), .o_global_irq_enable(global_irq_enable), .o_request_one(req1));

	initial begin
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge i_ref_clk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge i_ref_clk);
			if (arvalid && arready)
				arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic wchk(input logic [7:0] a, input logic [7:0] d);
		wr(a, {24'h00_0000, d}, resp);
		check("write response", {30'h0, pief_pkg::RESP_OKAY}, {30'h0, resp});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		rd(a, rdat, resp);
		check(what, {24'h00_0000, exp}, rdat);
		check("read response", {30'h0, pief_pkg::RESP_OKAY}, {30'h0, resp});
	endtask

	task automatic fire(input logic [3:0] p);
		@(posedge i_ref_clk);
		go <= 1'h1;
		pick <= p;
		@(posedge i_ref_clk);
		go <= 1'h0;
		cyc(2);
	endtask

	task automatic irq_chk(input logic exp);
		cyc(3);
		check("peripheral request", {31'h0, exp}, {31'h0, irq});
	endtask

	task automatic wrap_up;
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		cyc(5000);
		error_cnt++;
		$display("ERROR watchdog expected finish seen hang");
		wrap_up();
	end

	initial begin
		cyc(8);
		i_rst <= 1'h0;
		cyc(2);
		for (int k = 0; k < 4; k++)
			rchk(8'(4 * k), pief_pkg::RST_VALUE, "reset value");
		// Enables all off here, so every flag must still set
		foreach (rows[k]) begin
			mode <= rows[k].mode;
			fire(rows[k].ev1);
			rchk(RQ, rows[k].exp1, "flag after event");
			check("request copy", {24'h0, rows[k].exp1}, {24'h0, req1});
			if (rows[k].ev2 == 4'hF)
				wchk(RQ, 8'h00);
			else
				fire(rows[k].ev2);
			rchk(RQ, rows[k].exp2, "flag after clear");
		end
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'hFF);
		rchk(pief_pkg::OFF_ENABLE_TWO, 8'hF0, "enable two");
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'hA5);
		rchk(pief_pkg::OFF_ENABLE_TWO, 8'hA0, "enable two");
		wchk(RQ, 8'hFF);
		rchk(RQ, 8'h4F, "read-only flags");
		wchk(RQ, 8'h00);
		// Event pulse lands in the same cycle as the clearing write
		fork
			wchk(RQ, 8'h00);
			fire(4'h0);
		join
		rchk(RQ, 8'h40, "set beats clear");
		wchk(RQ, 8'h00);
		wr(8'h10, 32'h0000_00FF, resp);
		check("unmapped write", {30'h0, pief_pkg::RESP_SLVERR}, {30'h0, resp});
		rd(8'h10, rdat, resp);
		check("unmapped read", {30'h0, pief_pkg::RESP_SLVERR}, {30'h0, resp});
		check("unmapped data", 32'h0000_0000, rdat);
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'h00);
		strb <= 4'hE;
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'hF0);
		strb <= 4'hF;
		rchk(pief_pkg::OFF_ENABLE_TWO, 8'h00, "lane zero off");
		fire(4'h9);
		irq_chk(1'h0);
		wchk(pief_pkg::OFF_ENABLE_ONE, 8'h01);
		irq_chk(1'h0);
		wchk(pief_pkg::OFF_IRQ_CONTROL, 8'h80);
		irq_chk(1'h0);
		check("global enable", 32'h1, {31'h0, global_irq_enable});
		wchk(pief_pkg::OFF_IRQ_CONTROL, 8'h40);
		irq_chk(1'h1);
		wchk(RQ, 8'h00);
		irq_chk(1'h0);
		req2 <= 4'h8;
		irq_chk(1'h0);
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'h40);
		irq_chk(1'h0);
		wchk(pief_pkg::OFF_ENABLE_TWO, 8'h80);
		irq_chk(1'h1);
		@(posedge i_ref_clk);
		i_rst <= 1'h1;
		cyc(2);
		i_rst <= 1'h0;
		cyc(2);
		rchk(pief_pkg::OFF_ENABLE_TWO, 8'h00, "enable two after reset");
		rchk(pief_pkg::OFF_IRQ_CONTROL, 8'h00, "control after reset");
		irq_chk(1'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
